// ==== byte_buffer.sv ====
// Two-entry skid buffer on the byte stream toward the data buffer
`timescale 1ns/1ps
`default_nettype none
module byte_buffer
  import seclen_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic cen,
  // Stream
  byte_path_if.buffer bp
);
  logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt;
  logic [7:0] head_r, head_nxt, tail_r, tail_nxt;
  logic pop;

  // ==========================================================
  // Next state
  // Head is always the older word, so the output stays a flip-flop
  always_comb
  begin
    pop = head_v_r & bp.pop_ready;
    head_v_nxt = head_v_r;
    head_nxt = head_r;
    tail_v_nxt = tail_v_r;
    tail_nxt = tail_r;
    if (pop)
    begin
      if (tail_v_r)
      begin
        head_nxt = tail_r;
        tail_v_nxt = bp.push_valid;
        tail_nxt = bp.push_data;
      end
      else
      begin
        head_v_nxt = bp.push_valid;
        head_nxt = bp.push_data;
      end
    end
    else if (bp.push_valid)
    begin
      if (!head_v_r)
      begin
        head_v_nxt = 1'b1;
        head_nxt = bp.push_data;
      end
      else
      begin
        tail_v_nxt = 1'b1;
        tail_nxt = bp.push_data;
      end
    end
    bp.level_nxt = {1'b0, head_v_nxt} + {1'b0, tail_v_nxt};
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      head_r <= BYTE_RST;
      tail_r <= BYTE_RST;
    end
    else if (cen)
    begin
      head_v_r <= head_v_nxt;
      tail_v_r <= tail_v_nxt;
      head_r <= head_nxt;
      tail_r <= tail_nxt;
    end
  end

  assign bp.pop_valid = head_v_r;
  assign bp.pop_data = head_r;
endmodule // byte_buffer
`default_nettype wire

// ==== byte_partner.sv ====
// Serializer source and data buffer sink facing the counter
`timescale 1ns/1ps
`default_nettype none
module byte_partner
(
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  // Streams
  output logic in_valid,
  output logic [7:0] in_data,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  // Tallies
  output logic [15:0] rx_cnt,
  output logic order_bad
);
  logic [7:0] tx_r;
  logic [1:0] pace_r;
  // Source offers a counting pattern; sink takes one in four when slow
  assign in_valid = !rst;
  assign in_data = tx_r;
  assign out_ready = !slow || pace_r == 2'h3;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_r <= 8'h00;
      pace_r <= 2'h0;
      rx_cnt <= 16'h0000;
      order_bad <= 1'b0;
    end
    else
    begin
      pace_r <= pace_r + 2'h1;
      if (in_valid && in_ready)
        tx_r <= tx_r + 8'h01;
      if (out_valid && out_ready)
        rx_cnt <= rx_cnt + 16'h0001;
      if (out_valid && out_ready && out_data !== rx_cnt[7:0])
        order_bad <= 1'b1;
    end
  end
endmodule // byte_partner
`default_nettype wire

// ==== byte_path_if.sv ====
// Byte stream between the length counter and its two-entry buffer
`timescale 1ns/1ps
`default_nettype none
interface byte_path_if;
  logic push_valid;
  logic [7:0] push_data;
  logic pop_valid;
  logic [7:0] pop_data;
  logic pop_ready;
  logic [1:0] level_nxt;

  modport counter (output push_valid, output push_data, input level_nxt);
  modport buffer (input push_valid, input push_data, input pop_ready,
    output pop_valid, output pop_data, output level_nxt);
endinterface
`default_nettype wire

// ==== seclen_asserts.sv ====
// Port checker for the sector length counter
`timescale 1ns/1ps
`default_nettype none
module seclen_asserts
  import seclen_pkg::*;
(
  // Clocking
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Registers
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Streams
  input wire logic BYTE_IN_VALID,
  input wire logic [7:0] BYTE_IN_DATA,
  input wire logic BYTE_IN_READY,
  input wire logic BYTE_OUT_VALID,
  input wire logic [7:0] BYTE_OUT_DATA,
  input wire logic BYTE_OUT_READY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ====================
  // Read answers are checked at the edge after the read, where they first stand
  property p_rw(a, m);
    REG_WR && CLK_EN && REG_ADDR == a ##2 REG_RD && CLK_EN && REG_ADDR == a
      |=> (REG_RDATA & m) == ($past(REG_WDATA, 3) & m);
  endproperty
  a_seg_mult_rw: assert property (p_rw(SEG_MULT_OFS, 8'hFF))
    else $error("segment count readback");
  a_branch_rw: assert property (p_rw(BRANCH_OFS, 8'h1F))
    else $error("branch target readback");
  a_count_rw: assert property (p_rw(CS_BASE_OFS, 8'hFF))
    else $error("count field readback");
  a_unmapped_zero: assert property (REG_RD && CLK_EN && REG_ADDR == 8'h40 |=>
    REG_RDATA == 8'h00) else $error("unmapped read");
  a_start_self_clear: assert property (REG_RD && CLK_EN && REG_ADDR == OP_CTL_OFS
    |=> !REG_RDATA[OP_START_BIT]) else $error("start bit");
  a_active_flag: assert property (REG_RD && CLK_EN && REG_ADDR == SEQ_STAT_OFS &&
    BYTE_IN_READY |=> REG_RDATA[7:6] == 2'h3) else $error("active flag");
  a_out_hold: assert property (BYTE_OUT_VALID && !BYTE_OUT_READY && CLK_EN
    |=> BYTE_OUT_VALID && $stable(BYTE_OUT_DATA)) else $error("stalled byte lost");
  a_reset_quiet: assert property ($fell(SYS_RST) |-> !BYTE_IN_READY &&
    !BYTE_OUT_VALID && REG_RDATA == 8'h00) else $error("reset outputs");
  c_hold_start: cover property (REG_WR && REG_ADDR == OP_CTL_OFS && REG_WDATA == 8'h81);
  c_out_stall: cover property (BYTE_OUT_VALID && !BYTE_OUT_READY);
  c_full_stop: cover property (BYTE_IN_VALID && !BYTE_IN_READY && BYTE_OUT_VALID);
endmodule // seclen_asserts
bind sector_length_counter seclen_asserts u_seclen_asserts (.CLOCK, .SYS_RST, .CLK_EN,
  .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .BYTE_IN_VALID, .BYTE_IN_DATA,
  .BYTE_IN_READY, .BYTE_OUT_VALID, .BYTE_OUT_DATA, .BYTE_OUT_READY);
`default_nettype wire

// ==== seclen_pkg.sv ====
// Constants and types shared by the sector length counter and its buffer
package seclen_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] SEG_MULT_OFS = 8'h4E;
  localparam logic [7:0] BRANCH_OFS = 8'h78;
  localparam logic [7:0] SEQ_STAT_OFS = 8'h79;
  localparam logic [7:0] OP_CTL_OFS = 8'h7A;
  // Control store window: word i count at 2*i, control at 2*i+1
  localparam logic [7:0] CS_BASE_OFS = 8'h00;
  localparam logic [7:0] CS_LAST_OFS = 8'h3D;
  // ==========================================================
  // Sizes and field positions
  localparam int CS_WORDS = 31;
  localparam logic [4:0] CS_LAST_WORD = 5'h1E;
  localparam int CTL_XFER_BIT = 0;
  localparam int CTL_STOP_BIT = 6;
  localparam int CTL_BRANCH_BIT = 7;
  localparam int OP_START_BIT = 0;
  localparam int OP_HOLD_BIT = 7;
  localparam int STAT_ACTIVE_BIT = 6;
  localparam int STAT_BUSY_BIT = 7;
  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] COUNT_WRAP = 8'hFF;
  localparam logic [4:0] PC_RST = 5'h00;
  localparam logic [1:0] LEVEL_FULL = 2'h2;

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_XFER, S_WAIT} seq_state_t;
endpackage

// ==== sector_length_counter.sv ====
// Sector data field length counter with carry hold and control store sequencing
`timescale 1ns/1ps
`default_nettype none
module sector_length_counter
  import seclen_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Microcontroller register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Byte stream in from the serializer
  input wire logic BYTE_IN_VALID,
  input wire logic [7:0] BYTE_IN_DATA,
  output logic BYTE_IN_READY,
  // Byte stream out to the data buffer
  output logic BYTE_OUT_VALID,
  output logic [7:0] BYTE_OUT_DATA,
  input wire logic BYTE_OUT_READY
);
  // ==========================================================
  // Declarations
  logic [7:0] cs_count_mem [CS_WORDS];
  logic [7:0] cs_ctl_mem [CS_WORDS];
  seq_state_t state_r, state_nxt;
  logic [4:0] pc_r, pc_nxt;
  logic [7:0] count_r, count_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] seg_mult_r, seg_mult_nxt;
  logic [7:0] seg_left_r, seg_left_nxt;
  logic [7:0] branch_r, branch_nxt;
  logic [6:1] op_misc_r, op_misc_nxt;
  logic hold_r, hold_nxt;
  logic in_ready_r, in_ready_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic take, carry, start, wr_op;
  logic [4:0] next_pc;

  byte_path_if bp ();

  // True when the address falls in the control store window
  function automatic logic in_cs(input logic [7:0] a);
    return (a >= CS_BASE_OFS) && (a <= CS_LAST_OFS);
  endfunction

  // Control store word index for a window address
  function automatic logic [4:0] cs_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - CS_BASE_OFS;
    return d[5:1];
  endfunction

  byte_buffer u_buf (
    .clk(CLOCK),
    .rst(SYS_RST),
    .cen(CLK_EN),
    .bp(bp.buffer)
  );

  assign bp.push_valid = take;
  assign bp.push_data = BYTE_IN_DATA;
  assign bp.pop_ready = BYTE_OUT_READY;
  assign BYTE_OUT_VALID = bp.pop_valid;
  assign BYTE_OUT_DATA = bp.pop_data;
  assign BYTE_IN_READY = in_ready_r;

  // ==========================================================
  // Control store, written by the microcontroller at any time
  always_ff @(posedge CLOCK)
  begin
    if (CLK_EN && REG_WR && in_cs(REG_ADDR))
    begin
      if (REG_ADDR[0] == CS_BASE_OFS[0])
        cs_count_mem[cs_index(REG_ADDR)] <= REG_WDATA;
      else
        cs_ctl_mem[cs_index(REG_ADDR)] <= REG_WDATA;
    end
  end

  // ==========================================================
  // Sequencer and length counter
  always_comb
  begin
    take = BYTE_IN_VALID & in_ready_r;
    wr_op = REG_WR && (REG_ADDR == OP_CTL_OFS);
    start = wr_op && REG_WDATA[OP_START_BIT];
    carry = 1'b0;
    state_nxt = state_r;
    pc_nxt = pc_r;
    count_nxt = count_r;
    ctl_nxt = ctl_r;
    hold_nxt = hold_r;
    seg_left_nxt = seg_left_r;
    next_pc = pc_r + 5'd1;
    if (ctl_r[CTL_BRANCH_BIT])
      next_pc = branch_r[4:0];
    unique case (state_r)
      S_IDLE:
      begin
        if (start)
        begin
          pc_nxt = branch_r[4:0];
          state_nxt = S_FETCH;
        end
      end
      S_FETCH:
      begin
        // A word index past the store has nothing to run
        if (pc_r > CS_LAST_WORD)
          state_nxt = S_IDLE;
        else
        begin
          count_nxt = cs_count_mem[pc_r];
          ctl_nxt = cs_ctl_mem[pc_r];
          state_nxt = cs_ctl_mem[pc_r][CTL_XFER_BIT] ? S_XFER : S_WAIT;
        end
      end
      S_XFER, S_WAIT:
      begin
        // Transfer words count bytes, the others count cycles
        if (take || state_r == S_WAIT)
        begin
          if (count_r == BYTE_RST)
            carry = 1'b1;
          else
            count_nxt = count_r - 8'd1;
        end
        if (carry && hold_r && state_r == S_XFER)
        begin
          count_nxt = COUNT_WRAP;
          if (seg_left_r == BYTE_RST)
            hold_nxt = 1'b0;
          else
            seg_left_nxt = seg_left_r - 8'd1;
        end
        else if (carry)
        begin
          pc_nxt = next_pc;
          if (ctl_r[CTL_STOP_BIT])
            state_nxt = S_IDLE;
          else
            state_nxt = S_FETCH;
        end
      end
    endcase
    // Software write comes last so a set in the clearing cycle wins
    if (wr_op)
    begin
      hold_nxt = REG_WDATA[OP_HOLD_BIT];
      if (REG_WDATA[OP_HOLD_BIT])
        seg_left_nxt = seg_mult_r;
    end
    // Ready only with a free slot, so no byte is ever dropped
    in_ready_nxt = (state_nxt == S_XFER) && (bp.level_nxt != LEVEL_FULL);
  end

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_r <= S_IDLE;
      pc_r <= PC_RST;
      count_r <= BYTE_RST;
      ctl_r <= BYTE_RST;
      hold_r <= 1'b0;
      seg_left_r <= BYTE_RST;
      in_ready_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      count_r <= count_nxt;
      ctl_r <= ctl_nxt;
      hold_r <= hold_nxt;
      seg_left_r <= seg_left_nxt;
      in_ready_r <= in_ready_nxt;
    end
  end

  // ==========================================================
  // Register file
  always_comb
  begin
    seg_mult_nxt = seg_mult_r;
    branch_nxt = branch_r;
    op_misc_nxt = op_misc_r;
    rdata_nxt = rdata_r;
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        SEG_MULT_OFS: seg_mult_nxt = REG_WDATA;
        BRANCH_OFS: branch_nxt = REG_WDATA;
        OP_CTL_OFS: op_misc_nxt = REG_WDATA[6:1];
        default: ;
      endcase
    end
    if (REG_RD)
    begin
      rdata_nxt = BYTE_RST;
      if (in_cs(REG_ADDR))
        rdata_nxt = (REG_ADDR[0] == CS_BASE_OFS[0]) ? cs_count_mem[cs_index(REG_ADDR)]
                                                   : cs_ctl_mem[cs_index(REG_ADDR)];
      else
      begin
        unique case (REG_ADDR)
          SEG_MULT_OFS: rdata_nxt = seg_mult_r;
          BRANCH_OFS: rdata_nxt = branch_r;
          SEQ_STAT_OFS:
          begin
            rdata_nxt = {3'h0, pc_r};
            rdata_nxt[STAT_ACTIVE_BIT] = (state_r == S_XFER);
            rdata_nxt[STAT_BUSY_BIT] = (state_r != S_IDLE);
          end
          OP_CTL_OFS: rdata_nxt = {hold_r, op_misc_r, 1'b0};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      seg_mult_r <= BYTE_RST;
      branch_r <= BYTE_RST;
      op_misc_r <= 6'h00;
      rdata_r <= BYTE_RST;
    end
    else if (CLK_EN)
    begin
      seg_mult_r <= seg_mult_nxt;
      branch_r <= branch_nxt;
      op_misc_r <= op_misc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
endmodule // sector_length_counter
`default_nettype wire

// ==== sector_length_counter_bench.sv ====
// Self-checking bench for the sector length counter
`timescale 1ns/1ps
`default_nettype none
module sector_length_counter_bench
  import seclen_pkg::*;
;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, slow = 1'b0;
  logic CLK_EN = 1'b1;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, BYTE_IN_DATA, BYTE_OUT_DATA, rd_v;
  logic BYTE_IN_VALID, BYTE_IN_READY, BYTE_OUT_VALID, BYTE_OUT_READY, order_bad;
  logic [15:0] rx_cnt, base;
  int n_mismatch = 0;
  int n_tests = 0;
  // Rows: address, written value, value read back
  logic [7:0] rows[9][3] = '{'{8'h79, 8'hFF, 8'h00}, '{8'h4E, 8'h5A, 8'h5A},
    '{8'h78, 8'h1F, 8'h1F}, '{8'h00, 8'hFF, 8'hFF}, '{8'h01, 8'hC1, 8'hC1},
    '{8'h40, 8'h77, 8'h00}, '{8'h7A, 8'h7E, 8'h7E}, '{8'h3D, 8'hAA, 8'hAA},
    '{8'h3E, 8'h55, 8'h00}};
  sector_length_counter u_sector_length_counter (.CLOCK, .SYS_RST, .CLK_EN, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .BYTE_IN_VALID, .BYTE_IN_DATA, .BYTE_IN_READY,
    .BYTE_OUT_VALID, .BYTE_OUT_DATA, .BYTE_OUT_READY);
  byte_partner u_byte_partner (.clk(CLOCK), .rst(SYS_RST), .slow, .in_valid(BYTE_IN_VALID),
    .in_data(BYTE_IN_DATA), .in_ready(BYTE_IN_READY), .out_valid(BYTE_OUT_VALID),
    .out_data(BYTE_OUT_DATA), .out_ready(BYTE_OUT_READY), .rx_cnt, .order_bad);
  initial forever #5 CLOCK = ~CLOCK;
  // ====================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLOCK);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge CLOCK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLOCK);
    REG_RD = 1'b0;
    rd_v = REG_RDATA;
  endtask
  // Start, look at status mid-transfer, then count what reached the sink
  // The branch target is rewritten just after the start, as software does mid-sector
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] br, input logic [15:0] n);
    base = rx_cnt;
    wr(OP_CTL_OFS, cmd);
    wr(BRANCH_OFS, br);
    repeat (4) @(negedge CLOCK);
    rd(SEQ_STAT_OFS);
    chk({14'h0000, rd_v[7:6]}, 16'h0003);
    for (int k = 0; k < 3000 && rx_cnt !== base + n; k++)
      @(negedge CLOCK);
    repeat (20) @(negedge CLOCK);
    chk(rx_cnt, base + n);
    chk({15'h0000, order_bad}, 16'h0000);
    rd(SEQ_STAT_OFS);
    chk({14'h0000, rd_v[7:6]}, 16'h0000);
    $display("test transfer of %0d bytes done", n);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    finish_test;
  end
  // ====================
  // Main sequence
  initial
  begin
    repeat (16) @(negedge CLOCK);
    SYS_RST = 1'b0;
    chk(16'({BYTE_IN_READY, BYTE_OUT_VALID, REG_RDATA}), 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0]);
      chk({8'h00, rd_v}, {8'h00, rows[i][2]});
    end
    // Frozen clock enable must drop the write
    CLK_EN = 1'b0;
    wr(SEG_MULT_OFS, 8'hA5);
    CLK_EN = 1'b1;
    rd(SEG_MULT_OFS);
    chk({8'h00, rd_v}, 16'h005A);
    $display("test registers done");
    // Lengths are programmed minus one: one byte, then a full 256, slow sink
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'h41);
    wr(BRANCH_OFS, 8'h00);
    slow = 1'b1;
    xfer(8'h01, 8'h00, 16'h0001 + 16'h0100);
    slow = 1'b0;
    wr(8'h00, 8'h13);
    wr(8'h01, 8'h41);
    wr(SEG_MULT_OFS, 8'h01);
    xfer(8'h81, 8'h00, 16'h0014 + 16'h0200);
    rd(OP_CTL_OFS);
    chk({15'h0000, rd_v[OP_HOLD_BIT]}, 16'h0000);
    wr(SEG_MULT_OFS, 8'h00);
    xfer(8'h81, 8'h00, 16'h0014 + 16'h0100);
    // Word 0 moves 64 bytes, word 1 waits one cycle and branches to word 5 for 4 more
    wr(8'h00, 8'h3F);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h80);
    wr(8'h0A, 8'h03);
    wr(8'h0B, 8'h41);
    xfer(8'h01, 8'h05, 16'h0040 + 16'h0004);
    // Start from word 0 again so the reset lands in a running transfer
    wr(BRANCH_OFS, 8'h00);
    wr(SEG_MULT_OFS, 8'h02);
    wr(OP_CTL_OFS, 8'h01);
    repeat (6) @(negedge CLOCK);
    SYS_RST = 1'b1;
    repeat (16) @(negedge CLOCK);
    SYS_RST = 1'b0;
    chk(16'({BYTE_IN_READY, BYTE_OUT_VALID, REG_RDATA}), 16'h0000);
    rd(SEG_MULT_OFS);
    chk({8'h00, rd_v}, 16'h0000);
    $display("test mid-run reset done");
    finish_test;
  end
endmodule // sector_length_counter_bench
`default_nettype wire
